// [design/fault_timer_pkg.sv]
/*
  Constants for the software fault watchdog: register layout, reset
  values and timing counts.
  Assumes a 250 MHz core clock; one CPU machine cycle is one clock here.
*/
package fault_timer_pkg;
  // ----------------------------------------------------------------
  // Register layout
  // ----------------------------------------------------------------
  localparam int ACT_BIT = 7;
  localparam int TOP_BIT = 6;
  localparam int COUNT_W = 7;
  localparam logic [7:0] REG_RESET = 8'h7F;
  localparam logic [6:0] TRIP_FROM = 7'h40;
  localparam logic [6:0] TRIP_TO = 7'h3F;
  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int PRESCALE_CYCLES = 16000;
  localparam int CLK_MHZ = 250;
  localparam int PULSE_US = 30;
  localparam int PULSE_CYCLES = PULSE_US * CLK_MHZ;
  localparam int PRE_W = 16;
  localparam int PULSE_W = 16;
endpackage : fault_timer_pkg

// [design/tick_if.sv]
/*
  Interface carrying the prescaler tick between watchdog modules.
  Assumes one clock domain.
*/
interface tick_if;
  logic tick;
  modport src (output tick);
  modport dst (input tick);
endinterface : tick_if

// [design/tick_prescaler.sv]
/*
  Free-running prescaler that emits one tick each period.
  Assumes the period fits in PRE_W bits.
*/
module tick_prescaler
  import fault_timer_pkg::*;
#(
  parameter int PERIOD = PRESCALE_CYCLES
) (
  input wire logic ref_clk_i,
  input wire logic reset_i,
  tick_if.src tk
);
  logic [PRE_W-1:0] cnt;
  logic [PRE_W-1:0] next_cnt;
  logic next_tick;

  initial begin
    if (PERIOD < 2 || PERIOD >= (1 << PRE_W)) $error("bad PERIOD");
  end

  // Never reloaded by writes, so the first tick after a write can come early
  always_comb begin
    next_tick = (cnt == PRE_W'(PERIOD - 1));
    next_cnt = next_tick ? '0 : cnt + 1'b1;
  end

  always_ff @(posedge ref_clk_i or posedge reset_i) begin
    if (reset_i) begin
      cnt <= '0;
      tk.tick <= 1'b0;
    end else begin
      cnt <= next_cnt;
      tk.tick <= next_tick;
    end
  end
endmodule : tick_prescaler

// [design/watchdog_timer.sv]
/*
  Software fault watchdog: 7-bit free-running downcounter with
  activation bit, software reset, halt reset and hardware option.
  Assumes option inputs are static and sync with ref_clk_i; the chip
  reset pulse is fed back into reset_i by the surroundings.
*/
module watchdog_timer
  import fault_timer_pkg::*;
#(
  parameter int PERIOD = PRESCALE_CYCLES,
  parameter int PULSE = PULSE_CYCLES
) (
  input wire logic ref_clk_i,
  input wire logic reset_i,
  input wire logic wr_en_i,
  input wire logic [7:0] wr_data_i,
  input wire logic halt_exec_i,
  input wire logic hw_watchdog_opt_i,
  input wire logic halt_reset_option_i,
  output logic [7:0] control_counter_reg_o,
  output logic chip_reset_n_o,
  output logic halt_enter_o
);
  import fault_timer_pkg::*;

  initial begin
    if (PULSE < 1 || PULSE >= (1 << PULSE_W)) $error("bad PULSE");
  end

  // ----------------------------------------------------------------
  // Prescaler
  // ----------------------------------------------------------------
  tick_if tk ();

  tick_prescaler #(.PERIOD(PERIOD)) u_pre (
    .ref_clk_i(ref_clk_i),
    .reset_i(reset_i),
    .tk(tk)
  );

  // ----------------------------------------------------------------
  // Counter and activation
  // ----------------------------------------------------------------
  logic activation_bit;
  logic next_activation_bit;
  logic [COUNT_W-1:0] count;
  logic [COUNT_W-1:0] next_count;
  logic active;
  logic trip;
  logic next_trip;

  // ----------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------
  // Halt becomes a reset only while armed and the option allows it
  function automatic logic halt_resets(input logic act, input logic opt);
    return act & opt;
  endfunction : halt_resets

  assign active = activation_bit | hw_watchdog_opt_i;

  always_comb begin
    next_activation_bit = activation_bit;
    next_count = count;
    next_trip = 1'b0;
    if (wr_en_i) begin
      // Set only; clearing needs a reset
      next_activation_bit = activation_bit | wr_data_i[ACT_BIT];
      next_count = wr_data_i[COUNT_W-1:0];
      if ((wr_data_i[ACT_BIT] | active) & ~wr_data_i[TOP_BIT]) begin
        next_trip = 1'b1;
      end
    end else if (tk.tick) begin
      next_count = count - 1'b1;
      if (active && count == TRIP_FROM) begin
        next_trip = 1'b1;
      end
    end
    if (halt_exec_i && halt_resets(active, halt_reset_option_i)) begin
      next_trip = 1'b1;
    end
  end

  always_ff @(posedge ref_clk_i or posedge reset_i) begin
    if (reset_i) begin
      activation_bit <= 1'b0;
      count <= REG_RESET[COUNT_W-1:0];
      trip <= 1'b0;
    end else begin
      activation_bit <= next_activation_bit;
      count <= next_count;
      trip <= next_trip;
    end
  end

  // ----------------------------------------------------------------
  // Reset pulse and halt gating
  // ----------------------------------------------------------------
  logic [PULSE_W-1:0] pulse_cnt;
  logic [PULSE_W-1:0] next_pulse_cnt;
  logic next_halt_enter;
  logic [7:0] next_reg;

  always_comb begin
    next_pulse_cnt = pulse_cnt;
    if (trip) begin
      next_pulse_cnt = PULSE_W'(PULSE);
    end else if (pulse_cnt != '0) begin
      next_pulse_cnt = pulse_cnt - 1'b1;
    end
    // A halt that resets does not enter halt
    next_halt_enter = halt_exec_i &
      ~halt_resets(active, halt_reset_option_i);
    next_reg = {next_activation_bit, next_count};
  end

  always_ff @(posedge ref_clk_i or posedge reset_i) begin
    if (reset_i) begin
      pulse_cnt <= '0;
      halt_enter_o <= 1'b0;
      control_counter_reg_o <= {1'b0, REG_RESET[COUNT_W-1:0]};
      chip_reset_n_o <= 1'b1;
    end else begin
      pulse_cnt <= next_pulse_cnt;
      halt_enter_o <= next_halt_enter;
      control_counter_reg_o <= next_reg;
      chip_reset_n_o <= (next_pulse_cnt == '0);
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  AST_TRIP_ON_ROLL: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    (tk.tick && !wr_en_i && active && count == TRIP_FROM)
    |=> ##1 !chip_reset_n_o)
    else $error("no reset on 40h to 3Fh");
  AST_NO_TRIP_IDLE: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    (!active && !wr_en_i && !halt_exec_i) |=> !trip)
    else $error("reset while inactive");
  AST_DEC: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    (tk.tick && !wr_en_i) |=> count == $past(count) - 7'h01)
    else $error("count not decremented");
  AST_HOLD: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    (!tk.tick && !wr_en_i) |=> $stable(count))
    else $error("count moved without tick");
  AST_STICKY: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    activation_bit |=> activation_bit)
    else $error("activation cleared");
  AST_LOAD: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    wr_en_i |=> count == $past(wr_data_i[6:0]))
    else $error("write not loaded");
  AST_SW_RESET: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    (wr_en_i && wr_data_i[7] && !wr_data_i[6]) |=> ##1 !chip_reset_n_o)
    else $error("no software reset");
  AST_HALT: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    (halt_exec_i && active && halt_reset_option_i)
    |=> !halt_enter_o ##1 !chip_reset_n_o)
    else $error("halt not turned into reset");
  AST_PULSE: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    $fell(chip_reset_n_o) |-> !chip_reset_n_o [*8])
    else $error("reset pulse too short");
  AST_ROLL_VALUE: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    (tk.tick && !wr_en_i && count == TRIP_FROM) |=> count == TRIP_TO)
    else $error("roll value wrong");
  AST_FREE_RUN: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    (tk.tick && !wr_en_i && !active) |=> count != $past(count))
    else $error("counter stopped while inactive");
  AST_ACT_SET: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    (wr_en_i && wr_data_i[ACT_BIT]) |=> activation_bit)
    else $error("activation not set");
  AST_HW_OPT: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    (hw_watchdog_opt_i && wr_en_i && !wr_data_i[TOP_BIT]) |=> trip)
    else $error("hardware option not active");
  AST_MIRROR: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    control_counter_reg_o == {activation_bit, count})
    else $error("readback differs from state");
  AST_REG_HOLD: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    (!wr_en_i && !tk.tick) |=> $stable(control_counter_reg_o))
    else $error("readback moved");
  AST_WR_NO_TRIP: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    (wr_en_i && wr_data_i[TOP_BIT] && !halt_exec_i) |=> !trip)
    else $error("refresh caused reset");
  AST_TICK_ONE: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    tk.tick |=> !tk.tick)
    else $error("tick longer than a cycle");

  // ----------------------------------------------------------------
  // Checks: pulse and halt
  // ----------------------------------------------------------------
  // Low pulse must track the counter exactly, retrigger included
  AST_PULSE_LEVEL: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    chip_reset_n_o == (pulse_cnt == '0))
    else $error("pulse level off counter");
  AST_PULSE_END: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    (pulse_cnt == PULSE_W'(1) && !trip) |=> chip_reset_n_o)
    else $error("pulse did not end");
  AST_TRIP_PULSE: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    trip |=> !chip_reset_n_o)
    else $error("trip without pulse");
  AST_HALT_PASS: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    (halt_exec_i && !(active && halt_reset_option_i)) |=> halt_enter_o)
    else $error("halt not entered");
  AST_NO_HALT: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    !halt_exec_i |=> !halt_enter_o)
    else $error("halt entered without request");
  AST_HALT_IDLE: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    (halt_exec_i && !active && !wr_en_i) |=> !trip)
    else $error("halt reset while inactive");
endmodule : watchdog_timer

// [testbench/watchdog_timer_test.sv]
/*
  Self-checking bench for watchdog_timer, short PERIOD and PULSE.
  Assumes fault_timer_pkg is compiled before this file.
*/
module watchdog_timer_test;
  import fault_timer_pkg::*;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int PER = 8;
  localparam int PUL = 10;
  logic ref_clk_i = 1'b0;
  logic reset_i = 1'b1;
  logic wr_en_i = 1'b0;
  logic [7:0] wr_data_i = 8'h00;
  logic halt_exec_i = 1'b0;
  logic hw_opt = 1'b0;
  logic halt_opt = 1'b0;
  logic [7:0] reg_o;
  logic rst_n;
  logic halt_o;
  int failures = 0;
  int n_compared = 0;
  int cnt;
  logic [7:0] rows_in [4] = '{8'h7F, 8'h50, 8'hC5, 8'h45};
  logic [7:0] rows_out [4] = '{8'h7F, 8'h50, 8'hC5, 8'hC5};
  always #2 ref_clk_i = ~ref_clk_i;
  watchdog_timer #(.PERIOD(PER), .PULSE(PUL)) dut (
    .ref_clk_i(ref_clk_i),
    .reset_i(reset_i),
    .wr_en_i(wr_en_i),
    .wr_data_i(wr_data_i),
    .halt_exec_i(halt_exec_i),
    .hw_watchdog_opt_i(hw_opt),
    .halt_reset_option_i(halt_opt),
    .control_counter_reg_o(reg_o),
    .chip_reset_n_o(rst_n),
    .halt_enter_o(halt_o)
  );
  // ----------------------------------------------------------------
  // Tasks; every drive lands by NBA on a rising edge
  // ----------------------------------------------------------------
  task automatic final_report();
    $display("compared %0d failed %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : final_report
  task automatic chk(input logic [7:0] got, input logic [7:0] exp,
                     input string m);
    n_compared++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask : chk
  task automatic step(input int n);
    repeat (n) @(posedge ref_clk_i);
    #1;
  endtask : step
  task automatic rst(input int n);
    @(posedge ref_clk_i);
    reset_i <= 1'b1;
    repeat (n) @(posedge ref_clk_i);
    reset_i <= 1'b0;
    #1;
  endtask : rst
  task automatic opt(input logic h, input logic o);
    @(posedge ref_clk_i);
    hw_opt <= h;
    halt_opt <= o;
  endtask : opt
  task automatic wr(input logic [7:0] d);
    @(posedge ref_clk_i);
    wr_en_i <= 1'b1;
    wr_data_i <= d;
    @(posedge ref_clk_i);
    wr_en_i <= 1'b0;
    #1;
  endtask : wr
  task automatic hlt();
    @(posedge ref_clk_i);
    halt_exec_i <= 1'b1;
    @(posedge ref_clk_i);
    halt_exec_i <= 1'b0;
    #1;
  endtask : hlt
  // Bounded wait: 0 reset low, 1 halt accepted, 2 register equals v
  task automatic wait_on(input int sel, input logic [7:0] v, input int lim);
    n_compared++;
    for (int i = 0; i <= lim; i++) begin
      if ((sel == 0 && rst_n === 1'b0) || (sel == 1 && halt_o === 1'b1) ||
          (sel == 2 && reg_o === v)) return;
      step(1);
    end
    failures++;
    $display("[FAIL] %0t wait %0d timed out", $time, sel);
    final_report();
  endtask : wait_on
  initial begin
    rst(16);
    chk(reg_o, REG_RESET, "reset value");
    chk({7'h00, rst_n}, 8'h01, "reset idle");
    for (int r = 0; r < 4; r++) begin
      wr(rows_in[r]);
      chk(reg_o, rows_out[r], "readback");
    end
    $display("table done");
    rst(2);
    wr(8'h05);
    wait_on(2, 8'h04, PER + 2);
    step(PER - 1);
    chk(reg_o, 8'h04, "early tick");
    wait_on(2, 8'h03, 2);
    wr(8'h41);
    wait_on(2, 8'h3F, 2 * PER + 2);
    step(3);
    chk({7'h00, rst_n}, 8'h01, "inactive trip");
    $display("count done");
    // Two steps of timeout from 41h, so the trip must follow two ticks
    wr(8'hC1);
    wait_on(0, 8'h00, 2 * PER + 4);
    pulse_chk();
    rst(2);
    chk({7'h00, reg_o[ACT_BIT]}, 8'h00, "act after reset");
    wr(8'hC5);
    wr(8'h85);
    wait_on(0, 8'h00, 3);
    $display("trip done");
    opt(1'b0, 1'b1);
    rst(2);
    hlt();
    wait_on(1, 8'h00, 3);
    wr(8'hFF);
    hlt();
    wait_on(0, 8'h00, 3);
    opt(1'b0, 1'b0);
    rst(2);
    wr(8'hFF);
    hlt();
    wait_on(1, 8'h00, 3);
    step(3);
    chk({7'h00, rst_n}, 8'h01, "halt kept");
    opt(1'b1, 1'b1);
    rst(2);
    hlt();
    wait_on(0, 8'h00, 3);
    rst(2);
    wr(8'h05);
    wait_on(0, 8'h00, 3);
    $display("halt done");
    final_report();
  end
  task automatic pulse_chk();
    cnt = 0;
    while (rst_n === 1'b0 && cnt < 100) begin
      cnt++;
      step(1);
    end
    chk(8'(cnt), 8'(PUL), "pulse length");
  endtask : pulse_chk
endmodule : watchdog_timer_test
